// ---- hdl/qdp_pkg.sv ----
// Package for the quad converter parallel-port host controller
package qdp_pkg;
    localparam int DATA_W = 16;
    localparam int SETUP_NS = 20;
    localparam int PULSE_NS = 40;
    localparam int CLK_NS = 20;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] ZERO_CODE = 16'h0000;

    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_IDLE = 4'h1,
        ST_RW = 4'h3,
        ST_DATA = 4'h2,
        ST_ADDR = 4'h6,
        ST_CSLO = 4'h7,
        ST_CSHI = 4'h5,
        ST_STRB = 4'h4,
        ST_SLO = 4'hc
    } qdp_state_t;

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ = 2'h1,
        OP_LOAD = 2'h2,
        OP_CLEAR = 2'h3
    } qdp_op_t;

    typedef struct packed {
        qdp_op_t op;
        logic [1:0] chan;
        logic [15:0] data;
    } qdp_req_t;

    typedef struct packed {
        logic cs_n;
        logic rd_wr;
        logic sel_hi;
        logic sel_lo;
        logic load;
        logic clear;
        logic sleep_n;
    } qdp_pins_t;

    typedef struct packed {
        qdp_state_t st;
        qdp_req_t req;
        logic [3:0] cnt;
        qdp_pins_t pins;
        logic [15:0] dout;
        logic dout_oe_n;
        logic [15:0] rdata;
        logic rvalid;
    } qdp_regs_t;
endpackage : qdp_pkg

// ---- hdl/qdp_host.sv ----
// Host-side controller driving the quad converter parallel port
`timescale 1ns/100ps
module qdp_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Supply status and sleep request
    input wire logic supplies_ok,
    input wire logic sleep_req,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input qdp_pkg::qdp_req_t req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Device pins
    output logic cs_n,
    output logic rd_wr,
    output logic channel_sel_hi,
    output logic channel_sel_lo,
    output logic load_outputs_strobe,
    output logic clear,
    output logic sleep_n,
    input wire logic [15:0] data_bus_i,
    output logic [15:0] data_bus_o,
    output logic data_bus_oe_n
);
    qdp_pkg::qdp_regs_t r_q;
    qdp_pkg::qdp_regs_t r_d;

    always_comb begin
        r_d = r_q;
        r_d.rvalid = 1'b0;
        if (r_q.cnt != 4'h0) begin
            r_d.cnt = r_q.cnt - 4'h1;
        end
        unique case (r_q.st)
            qdp_pkg::ST_OFF: begin
                r_d.pins = '0;
                r_d.dout = qdp_pkg::ZERO_CODE;
                r_d.dout_oe_n = 1'b0;
                if (supplies_ok) begin
                    r_d.pins.cs_n = 1'b1;
                    r_d.pins.sleep_n = 1'b1;
                    r_d.dout_oe_n = 1'b1;
                    r_d.st = qdp_pkg::ST_IDLE;
                end
            end
            qdp_pkg::ST_IDLE: begin
                r_d.pins.sleep_n = ~sleep_req;
                if (req_valid) begin
                    r_d.req = req;
                    r_d.cnt = qdp_pkg::SETUP_CYC;
                    if (req.op == qdp_pkg::OP_LOAD) begin
                        r_d.pins.load = 1'b1;
                        r_d.cnt = qdp_pkg::PULSE_CYC;
                        r_d.st = qdp_pkg::ST_STRB;
                    end else if (req.op == qdp_pkg::OP_CLEAR) begin
                        r_d.pins.clear = 1'b1;
                        r_d.cnt = qdp_pkg::PULSE_CYC;
                        r_d.st = qdp_pkg::ST_STRB;
                    end else begin
                        r_d.pins.rd_wr = 1'b0;
                        r_d.dout_oe_n = 1'b1;
                        r_d.st = qdp_pkg::ST_RW;
                    end
                end
            end
            qdp_pkg::ST_RW: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.cnt = qdp_pkg::SETUP_CYC;
                    if (r_q.req.op == qdp_pkg::OP_WRITE) begin
                        r_d.dout = r_q.req.data;
                        r_d.dout_oe_n = 1'b0;
                    end
                    r_d.st = qdp_pkg::ST_DATA;
                end
            end
            qdp_pkg::ST_DATA: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.pins.sel_hi = r_q.req.chan[1];
                    r_d.pins.sel_lo = r_q.req.chan[0];
                    r_d.cnt = qdp_pkg::SETUP_CYC;
                    r_d.st = qdp_pkg::ST_ADDR;
                end
            end
            qdp_pkg::ST_ADDR: begin
                // Lets a transfer parked behind sleep go on once sleep is dropped
                if (!r_q.pins.sleep_n) begin
                    r_d.pins.sleep_n = ~sleep_req;
                end
                if (r_q.cnt == 4'h0 && r_q.pins.sleep_n) begin
                    if (r_q.req.op == qdp_pkg::OP_READ && !r_q.pins.rd_wr) begin
                        // Read select rises only after the address has settled
                        r_d.pins.rd_wr = 1'b1;
                        r_d.cnt = qdp_pkg::SETUP_CYC;
                    end else begin
                        r_d.pins.cs_n = 1'b0;
                        r_d.cnt = qdp_pkg::PULSE_CYC;
                        r_d.st = qdp_pkg::ST_CSLO;
                    end
                end
            end
            qdp_pkg::ST_CSLO: begin
                if (r_q.cnt == 4'h0) begin
                    if (r_q.req.op == qdp_pkg::OP_READ) begin
                        r_d.rdata = data_bus_i;
                        r_d.rvalid = 1'b1;
                    end
                    r_d.pins.cs_n = 1'b1;
                    r_d.cnt = qdp_pkg::SETUP_CYC;
                    r_d.st = qdp_pkg::ST_CSHI;
                end
            end
            qdp_pkg::ST_CSHI: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.pins.rd_wr = 1'b0;
                    r_d.dout_oe_n = 1'b1;
                    r_d.st = qdp_pkg::ST_IDLE;
                end
            end
            qdp_pkg::ST_STRB: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.pins.load = 1'b0;
                    r_d.pins.clear = 1'b0;
                    r_d.cnt = qdp_pkg::PULSE_CYC;
                    r_d.st = qdp_pkg::ST_SLO;
                end
            end
            qdp_pkg::ST_SLO: begin
                if (r_q.cnt == 4'h0) begin
                    r_d.st = qdp_pkg::ST_IDLE;
                end
            end
            default: begin
                r_d.st = qdp_pkg::ST_OFF;
            end
        endcase
        if (!supplies_ok) begin
            r_d.st = qdp_pkg::ST_OFF;
            r_d.pins = '0;
            r_d.dout = qdp_pkg::ZERO_CODE;
            r_d.dout_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '{st: qdp_pkg::ST_OFF, req: '0, cnt: 4'h0, pins: '0,
                     dout: 16'h0000, dout_oe_n: 1'b0, rdata: 16'h0000, rvalid: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign req_ready = (r_q.st == qdp_pkg::ST_IDLE) && supplies_ok;
    assign rd_data = r_q.rdata;
    assign rd_valid = r_q.rvalid;
    assign cs_n = r_q.pins.cs_n;
    assign rd_wr = r_q.pins.rd_wr;
    assign channel_sel_hi = r_q.pins.sel_hi;
    assign channel_sel_lo = r_q.pins.sel_lo;
    assign load_outputs_strobe = r_q.pins.load;
    assign clear = r_q.pins.clear;
    assign sleep_n = r_q.pins.sleep_n;
    assign data_bus_o = r_q.dout;
    assign data_bus_oe_n = r_q.dout_oe_n;

    // Checks
    property p_no_cs_fall_in_sleep;
        @(posedge clk) disable iff (!rst_b) $fell(cs_n) |-> sleep_n;
    endproperty
    cs_sleep_a: assert property (p_no_cs_fall_in_sleep) else $error("cs fell while asleep");
    write_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_n) && !rd_wr |-> !data_bus_oe_n && $stable(data_bus_o))
        else $error("write data not driven");
    read_release_a: assert property (@(posedge clk) disable iff (!rst_b)
        !cs_n && rd_wr |-> data_bus_oe_n)
        else $error("bus driven during read");
    rw_stable_a: assert property (@(posedge clk) disable iff (!rst_b)
        !cs_n |-> $stable(rd_wr) && $stable(channel_sel_hi) && $stable(channel_sel_lo))
        else $error("ctrl moved");
    cs_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_n) |-> !cs_n [*3] ##1 cs_n)
        else $error("cs pulse width wrong");
    power_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        !supplies_ok |=> !cs_n && !sleep_n && !load_outputs_strobe && !clear)
        else $error("input high unpowered");
    load_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(load_outputs_strobe) |-> cs_n ##0 load_outputs_strobe [*3] ##1 !load_outputs_strobe)
        else $error("bad load pulse");
    clear_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(clear) && supplies_ok |-> clear [*3] ##1 !clear)
        else $error("bad clear pulse");
    chan_map_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_n) |-> {channel_sel_hi, channel_sel_lo} == r_q.req.chan)
        else $error("wrong channel");
    read_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cs_n) && rd_wr |-> ##[1:4] rd_valid)
        else $error("read not returned");
    // Pin ordering around a transfer; a supply drop forces every pin low at once
    rw_order_a: assert property (@(posedge clk) disable iff (!rst_b || !supplies_ok)
        $rose(rd_wr) |-> cs_n && data_bus_oe_n && $stable({channel_sel_hi, channel_sel_lo}))
        else $error("read select raised out of order");
    addr_order_a: assert property (@(posedge clk) disable iff (!rst_b || !supplies_ok)
        $changed({channel_sel_hi, channel_sel_lo}) |-> cs_n && !rd_wr)
        else $error("address moved out of order");
    data_order_a: assert property (@(posedge clk) disable iff (!rst_b || !supplies_ok)
        $changed(data_bus_o) |-> cs_n && !rd_wr)
        else $error("write data moved out of order");
    rd_sample_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd_valid |-> cs_n && !$past(cs_n) && $past(rd_wr))
        else $error("read word not taken at select rise");
    strobe_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(load_outputs_strobe) || $fell(clear) |-> (!load_outputs_strobe && !clear) [*3])
        else $error("strobe low time too short");
    sleep_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        req_ready |=> sleep_n == !$past(sleep_req))
        else $error("sleep pin not following request");

    // Coverage
    write_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(cs_n) && !rd_wr);
    read_c: cover property (@(posedge clk) disable iff (!rst_b) rd_valid);
    load_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(load_outputs_strobe));
    clear_sleep_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(clear) && !sleep_n);
    wake_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(sleep_n) && supplies_ok);
endmodule : qdp_host

// ---- tb/qdp_dev_model.sv ----
// Behavioural model of the quad converter behind its parallel port
`timescale 1ns/100ps
module qdp_dev_model (
    // Control pins
    input wire logic cs_n,
    input wire logic rd_wr,
    input wire logic channel_sel_hi,
    input wire logic channel_sel_lo,
    input wire logic load_outputs_strobe,
    input wire logic clear,
    input wire logic sleep_n,
    // Data bus
    input wire logic [15:0] bus_i,
    output logic [15:0] bus_o
);
    logic [15:0] in_reg [4];
    logic [15:0] dac_reg [4];
    logic [15:0] stale;
    logic wr_cycle;
    initial begin
        for (int i = 0; i < 4; i++) begin
            in_reg[i] = 16'h0000;
            dac_reg[i] = 16'h0000;
        end
        stale = 16'h5a5a;
        wr_cycle = 1'b0;
    end
    always @(negedge cs_n) wr_cycle = sleep_n && !rd_wr;
    always @(posedge cs_n) begin
        if (wr_cycle) in_reg[{channel_sel_hi, channel_sel_lo}] = bus_i;
        wr_cycle = 1'b0;
        stale = ~in_reg[{channel_sel_hi, channel_sel_lo}];
    end
    always @(posedge load_outputs_strobe) begin
        if (sleep_n) begin
            for (int i = 0; i < 4; i++) dac_reg[i] = in_reg[i];
        end
    end
    always @(posedge clear) begin
        for (int i = 0; i < 4; i++) dac_reg[i] = 16'h0000;
    end
    // Released bus shows a changed pattern, not the last word
    assign bus_o = (!cs_n && rd_wr && sleep_n) ? in_reg[{channel_sel_hi, channel_sel_lo}] : stale;
endmodule : qdp_dev_model

// ---- tb/tb.sv ----
// Self-checking bench for the parallel-port host controller
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        qdp_pkg::qdp_req_t rq;
        logic [15:0] exp;
    } qdp_row_t;
    logic clk, rst_b, supplies_ok, sleep_req, req_valid, req_ready, rd_valid;
    logic cs_n, rd_wr, sel_hi, sel_lo, load, clear, sleep_n, oe_n;
    logic [15:0] rd_data, bus_o, dev_o, bus_i, last_rd;
    qdp_pkg::qdp_req_t req;
    qdp_row_t rows [10];
    int errors = 0;
    int check_count = 0;
    assign bus_i = !oe_n ? bus_o : dev_o;
    qdp_host DUT (.clk(clk), .rst_b(rst_b), .supplies_ok(supplies_ok), .sleep_req(sleep_req), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .cs_n(cs_n), .rd_wr(rd_wr),
        .channel_sel_hi(sel_hi), .channel_sel_lo(sel_lo), .load_outputs_strobe(load), .clear(clear),
        .sleep_n(sleep_n), .data_bus_i(bus_i), .data_bus_o(bus_o), .data_bus_oe_n(oe_n));
    qdp_dev_model u_dev (.cs_n(cs_n), .rd_wr(rd_wr), .channel_sel_hi(sel_hi), .channel_sel_lo(sel_lo),
        .load_outputs_strobe(load), .clear(clear), .sleep_n(sleep_n), .bus_i(bus_i), .bus_o(dev_o));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic report_and_stop;
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word
    // Waits at falling edges for idle, catching the readback pulse
    task automatic wait_ready;
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (rd_valid === 1'b1) last_rd = rd_data;
            if (n > 40) begin
                errors++;
                report_and_stop();
            end
        end
    endtask : wait_ready
    task automatic do_req(input qdp_pkg::qdp_req_t r);
        @(negedge clk);
        wait_ready();
        req = r;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        wait_ready();
    endtask : do_req
    initial begin
        rst_b = 1'b0;
        supplies_ok = 1'b0;
        sleep_req = 1'b0;
        req_valid = 1'b0;
        req = '0;
        rows = '{'{'{qdp_pkg::OP_WRITE, 2'h0, 16'h1234}, 16'h0000}, '{'{qdp_pkg::OP_WRITE, 2'h1, 16'habcd}, 16'h0000},
            '{'{qdp_pkg::OP_WRITE, 2'h2, 16'hffff}, 16'h0000}, '{'{qdp_pkg::OP_WRITE, 2'h3, 16'h8001}, 16'h0000},
            '{'{qdp_pkg::OP_READ, 2'h0, 16'h0000}, 16'h1234}, '{'{qdp_pkg::OP_READ, 2'h3, 16'h0000}, 16'h8001},
            '{'{qdp_pkg::OP_LOAD, 2'h2, 16'h0000}, 16'hffff}, '{'{qdp_pkg::OP_READ, 2'h2, 16'h0000}, 16'hffff},
            '{'{qdp_pkg::OP_CLEAR, 2'h1, 16'h0000}, 16'h0000}, '{'{qdp_pkg::OP_READ, 2'h1, 16'h0000}, 16'habcd}};
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        chk_word({9'h000, cs_n, rd_wr, sel_hi, sel_lo, load, clear, sleep_n}, 16'h0000, "pins unpowered");
        supplies_ok = 1'b1;
        for (int i = 0; i < 4; i++) chk_word(u_dev.dac_reg[i], 16'h0000, "power-up code");
        foreach (rows[i]) begin
            last_rd = 16'hxxxx;
            do_req(rows[i].rq);
            if (rows[i].rq.op == qdp_pkg::OP_READ) begin
                chk_word(last_rd, rows[i].exp, "readback");
            end else if (rows[i].rq.op != qdp_pkg::OP_WRITE) begin
                chk_word(u_dev.dac_reg[rows[i].rq.chan], rows[i].exp, "dac code");
            end
        end
        do_req('{qdp_pkg::OP_LOAD, 2'h0, 16'h0000});
        chk_word(u_dev.dac_reg[3], 16'h8001, "load all");
        sleep_req = 1'b1;
        repeat (3) @(negedge clk);
        chk_word({15'h0000, sleep_n}, 16'h0000, "sleep pin");
        do_req('{qdp_pkg::OP_CLEAR, 2'h0, 16'h0000});
        chk_word(u_dev.dac_reg[3], 16'h0000, "clear asleep");
        sleep_req = 1'b0;
        repeat (3) @(negedge clk);
        chk_word({15'h0000, sleep_n}, 16'h0001, "wake pin");
        report_and_stop();
    end
endmodule : tb
